/* File: src/aicm_top.sv */
// Four-channel analog input monitor: faults, modes, scaling, framing
//
// Functional notes
// - Lead-break and short detection per channel, switched by an enable.
// - Live-zero bit set whenever current is below 3.6 mA, always.
// - Short reported when current exceeds the configured short threshold.
// - Lead break reported when current is below the break threshold.
// - Line fault raises a diagnostic and applies the error-mode value.
// - Module error flagged in module and global status when enabled.
// - Channel error report names slot, channel, direction and reason.
// - Normal mode passes field value; simulation passes preset value.
// - Current-value error mode keeps passing the present value.
// - Substitute error mode outputs the configured substitute value.
// - Last-valid mode holds the value from before the fault.
// - Scale to 0..65535 with start at 0 % and end at 100 %.
// - Status bits only with status option and default scaling.
// - HART enabled or disabled per channel.
// - HART setting changeable only when unit allows; else always active.
// - Active HART channels scanned by default; scan disableable per channel.
// - Status sits in the lowest bits, replacing the value's low four bits.
// - Live zero bit 0, line fault bit 1, 12-bit value above.
// - Channel words delivered every 6.5 ms regardless of conversion.
//
// Channel word with status and default scaling: value in bits 15:4, line
// fault in bit 1, live zero in bit 0, bits 3:2 zero. With any other scaling
// or without the status option all sixteen bits carry the value.
//
// Pipeline per channel: the sample edge registers current and raw flags; the
// next edge registers the scaled value and the aligned flags together; the
// frame tick then copies every channel word at once, so the unit always sees
// a consistent set regardless of when conversions finish.
//
// Limitation: a fault shorter than one frame period may never be visible in
// a delivered word, but it still raises its diagnostic report.
// Scaled values beyond the span are clamped only at 0 and 65535.
`timescale 1ns/10ps
module aicm_top #(
  parameter int NCH = aicm_pkg::AICM_NCH,
  parameter int FRAME_CYC = aicm_pkg::AICM_FRAME_CYC,
  parameter logic [3:0] SLOT_ID = 4'h0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] sample_valid,
  input wire logic [NCH*aicm_pkg::AICM_ADC_W-1:0] sample_code,
  input wire aicm_pkg::aicm_ch_cfg_t [NCH-1:0] ch_cfg,
  input wire logic mod_status_en,
  input wire logic hart_indiv_en,
  input wire logic hart_scan_ctl_en,
  output logic [NCH*aicm_pkg::AICM_WORD_W-1:0] ch_words,
  output logic frame_strobe,
  output logic [NCH-1:0] hart_active,
  output logic [NCH-1:0] hart_scan,
  output logic mod_status_err,
  output logic global_status_err,
  output logic diag_valid,
  output aicm_pkg::aicm_diag_t diag,
  input wire logic diag_ready
);
  import aicm_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // ADC code to microamps: code * 25000 / 4096
  function automatic logic [15:0] code_to_ua(input logic [11:0] code);
    logic [27:0] p;
    p = 28'(code) * 28'(AICM_FULL_UA);
    return p[27:12];
  endfunction

  // Status bits are only trusted with the factory scale
  function automatic logic is_default_scale(input aicm_ch_cfg_t c);
    return (c.scale_start == AICM_SCALE_START_DEF) && (c.scale_end == AICM_SCALE_END_DEF);
  endfunction

  // Short outranks break; with both clear the report falls back to live zero
  function automatic logic [1:0] reason_of(input logic sht, input logic brk);
    return sht ? AICM_REASON_SHORT : (brk ? AICM_REASON_BREAK : AICM_REASON_LZ);
  endfunction

  // ----------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------
  logic [NCH-1:0][15:0] cur_ua_q;
  logic [NCH-1:0] lz_q;
  logic [NCH-1:0] brk_q;
  logic [NCH-1:0] sht_q;
  logic [NCH-1:0][15:0] last_valid_q;
  logic [NCH-1:0][15:0] scaled;
  logic [NCH-1:0][15:0] out_word;
  logic [NCH-1:0] line_fault;
  logic [NCH-1:0] fault_rise;
  // Fault flags delayed one edge so they line up with the scaler's register
  logic [NCH-1:0] lz_al_q;
  logic [NCH-1:0] brk_al_q;
  logic [NCH-1:0] sht_al_q;

  genvar g;
  generate
    // Every channel runs the same slice in parallel
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] ua;
      logic [15:0] live_val;
      logic [15:0] sel_val;
      logic [15:0] word_d;
      logic lf_prev_q;
      logic st_ok;
      logic lz_hit;
      logic brk_hit;
      logic sht_hit;

      // Microamp view of the raw code; truncation costs under one microamp
      assign ua = code_to_ua(sample_code[g*AICM_ADC_W +: AICM_ADC_W]);

      // Live zero ignores the detection enable; break and short obey it
      assign lz_hit = (ua < AICM_LIVE_ZERO_UA);
      assign brk_hit = ch_cfg[g].lfd_en && (ua < ch_cfg[g].break_ua);
      assign sht_hit = ch_cfg[g].lfd_en && (ua > ch_cfg[g].short_ua);

      // Thresholds are checked only when a fresh sample lands
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          cur_ua_q[g] <= '0;
          lz_q[g] <= 1'b0;
          brk_q[g] <= 1'b0;
          sht_q[g] <= 1'b0;
        end else if (sample_valid[g]) begin
          cur_ua_q[g] <= ua;
          lz_q[g] <= lz_hit;
          brk_q[g] <= brk_hit;
          sht_q[g] <= sht_hit;
        end
      end

      // Flags step with the scaler so a clearing fault never passes the
      // stale, still-faulty scaled value off as a good word for one cycle
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          lz_al_q[g] <= 1'b0;
          brk_al_q[g] <= 1'b0;
          sht_al_q[g] <= 1'b0;
        end else begin
          lz_al_q[g] <= lz_q[g];
          brk_al_q[g] <= brk_q[g];
          sht_al_q[g] <= sht_q[g];
        end
      end

      // One scaler per channel: more area, but no latency shared between channels
      aicm_scaler u_scale (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cur_ua(cur_ua_q[g]),
        .scale_start(ch_cfg[g].scale_start),
        .scale_end(ch_cfg[g].scale_end),
        .scaled(scaled[g])
      );

      assign line_fault[g] = brk_al_q[g] | sht_al_q[g];
      // Simulation replaces the field value before the error strategy,
      // so a simulated value is also what the last-valid strategy keeps
      assign live_val = ch_cfg[g].sim_mode ? ch_cfg[g].sim_value : scaled[g];

      // Error strategy; a cleared fault falls back to the live value
      always_comb begin
        sel_val = live_val;
        if (line_fault[g]) begin
          case (ch_cfg[g].err_mode)
            AICM_ERR_CURRENT: sel_val = live_val;
            AICM_ERR_SUBST: sel_val = ch_cfg[g].subst_value;
            AICM_ERR_LAST: sel_val = last_valid_q[g];
            default: sel_val = live_val;
          endcase
        end
      end

      // Last valid value only tracks while fault-free
      // Reset value is zero: a fault before any good sample holds zero
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          last_valid_q[g] <= '0;
        end else if (!line_fault[g]) begin
          last_valid_q[g] <= live_val;
        end
      end

      // Status bits take the low nibble only with default scaling
      assign st_ok = ch_cfg[g].with_status && is_default_scale(ch_cfg[g]);
      always_comb begin
        word_d = sel_val;
        if (st_ok) begin
          word_d = {sel_val[15:AICM_VALUE_LSB], 4'h0};
          word_d[AICM_BIT_LIVE_ZERO] = lz_al_q[g];
          word_d[AICM_BIT_LINE_FAULT] = line_fault[g];
        end
      end
      assign out_word[g] = word_d;

      // Rising edge of a line fault triggers one diagnostic
      // Previous flag resets low, as idle, so reset makes no false onset
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          lf_prev_q <= 1'b0;
        end else begin
          lf_prev_q <= line_fault[g];
        end
      end
      assign fault_rise[g] = line_fault[g] & ~lf_prev_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fixed-period delivery to the communication unit
  // ----------------------------------------------------------------
  // Free-running beat; shrink FRAME_CYC only to shorten simulation
  logic [$clog2(FRAME_CYC)-1:0] frame_cnt_q;
  logic frame_tick;
  assign frame_tick = (frame_cnt_q == ($clog2(FRAME_CYC))'(FRAME_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frame_cnt_q <= '0;
    end else if (frame_tick) begin
      frame_cnt_q <= '0;
    end else begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  // Words latch once per period, independent of sample timing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ch_words <= '0;
      frame_strobe <= 1'b0;
    end else begin
      frame_strobe <= frame_tick;
      if (frame_tick) begin
        ch_words <= out_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Module and global status error flags
  // ----------------------------------------------------------------
  logic any_fault;
  // Live zero alone counts as a module error too
  assign any_fault = |(line_fault | lz_al_q);

  // Both flags share one source; the unit reads whichever it polls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mod_status_err <= 1'b0;
      global_status_err <= 1'b0;
    end else begin
      mod_status_err <= mod_status_en & any_fault;
      global_status_err <= mod_status_en & any_fault;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic reports: pending flags, lowest channel first
  // ----------------------------------------------------------------
  // Pending is sticky; a new fault in the clearing cycle is kept (set wins)
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] pend_clr;
  logic [NCH-1:0] pick;
  logic [1:0] pick_idx;
  logic pick_any;
  logic [1:0] pick_reason;

  // Fixed priority from channel 0; a busy low channel delays higher ones
  always_comb begin
    pick = '0;
    pick_idx = '0;
    pick_any = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (pend_q[i] && !pick_any) begin
        pick[i] = 1'b1;
        pick_idx = 2'(i);
        pick_any = 1'b1;
      end
    end
  end

  // A pick is retired only when the report register is free to take it
  assign pend_clr = (!diag_valid || diag_ready) ? pick : '0;
  assign pick_reason = reason_of(sht_al_q[pick_idx], brk_al_q[pick_idx]);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | fault_rise;
    end
  end

  // Report register holds until the unit takes it
  // and reloads on the taking edge, so reports may leave back to back
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diag_valid <= 1'b0;
      diag <= '0;
    end else if (!diag_valid || diag_ready) begin
      diag_valid <= pick_any;
      if (pick_any) begin
        diag.slot <= SLOT_ID;
        diag.channel <= pick_idx;
        diag.is_output <= 1'b0;
        diag.reason <= pick_reason;
      end
    end
  end

  // ----------------------------------------------------------------
  // HART activation and scanning
  // ----------------------------------------------------------------
  logic [NCH-1:0] act_req;
  logic [NCH-1:0] scan_req;
  // Raw requests only; the sub-block applies the unit's permissions
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      act_req[i] = ch_cfg[i].hart_active;
      scan_req[i] = ch_cfg[i].hart_scan;
    end
  end

  aicm_hart_ctl #(
    .NCH(NCH)
  ) u_hart (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .indiv_deact_en(hart_indiv_en),
    .scan_ctl_en(hart_scan_ctl_en),
    .active_req(act_req),
    .scan_req(scan_req),
    .hart_active(hart_active),
    .hart_scan(hart_scan)
  );
endmodule

/* File: src/aicm_pkg.sv */
// Package of constants and carriers for the analog input channel monitor
package aicm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int AICM_NCH = 4;
  localparam int AICM_ADC_W = 12;
  localparam int AICM_WORD_W = 16;

  // ----------------------------------------------------------------
  // Loop current thresholds, in microamps
  // ----------------------------------------------------------------
  localparam logic [15:0] AICM_LIVE_ZERO_UA = 16'h0e10; // 3600 uA
  localparam logic [15:0] AICM_SHORT_DEF_UA = 16'h5208; // 21000 uA
  localparam logic [15:0] AICM_BREAK_DEF_UA = 16'h03e8; // 1000 uA

  // ----------------------------------------------------------------
  // Scaling and word layout
  // ----------------------------------------------------------------
  localparam logic [15:0] AICM_SCALE_START_DEF = 16'h2710; // 10000
  localparam logic [15:0] AICM_SCALE_END_DEF = 16'hc350; // 50000
  localparam logic [15:0] AICM_WORD_MAX = 16'hffff; // 65535
  localparam int AICM_BIT_LIVE_ZERO = 0;
  localparam int AICM_BIT_LINE_FAULT = 1;
  localparam int AICM_VALUE_LSB = 4;
  localparam logic [3:0] AICM_STATUS_MASK = 4'hf;
  // ADC code 0..4095 spans 0..24993 uA, full scale 25000 uA
  localparam logic [15:0] AICM_FULL_UA = 16'h61a8; // 25000 uA
  localparam logic [15:0] AICM_UA_4MA = 16'h0fa0; // 4000 uA = 0 %
  localparam logic [15:0] AICM_UA_SPAN = 16'h3e80; // 16000 uA = 100 %

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int AICM_CLK_HZ = 10_000_000;
  localparam int AICM_FRAME_US = 6500; // 6.5 ms
  localparam int AICM_FRAME_CYC = (AICM_FRAME_US * (AICM_CLK_HZ / 1_000_000));

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AICM_ERR_CURRENT,
    AICM_ERR_SUBST,
    AICM_ERR_LAST
  } aicm_err_mode_t;

  typedef struct packed {
    logic sim_mode;
    aicm_err_mode_t err_mode;
    logic lfd_en;
    logic with_status;
    logic [15:0] short_ua;
    logic [15:0] break_ua;
    logic [15:0] scale_start;
    logic [15:0] scale_end;
    logic [15:0] sim_value;
    logic [15:0] subst_value;
    logic hart_active;
    logic hart_scan;
  } aicm_ch_cfg_t;

  typedef struct packed {
    logic [3:0] slot;
    logic [1:0] channel;
    logic is_output;
    logic [1:0] reason; // 0 none, 1 lead break, 2 short, 3 live zero
  } aicm_diag_t;

  localparam logic [1:0] AICM_REASON_BREAK = 2'h1;
  localparam logic [1:0] AICM_REASON_SHORT = 2'h2;
  localparam logic [1:0] AICM_REASON_LZ = 2'h3;

endpackage

/* File: src/aicm_scaler.sv */
// Scales one loop current into the 16-bit channel range
`timescale 1ns/10ps
module aicm_scaler (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] cur_ua,
  input wire logic [15:0] scale_start,
  input wire logic [15:0] scale_end,
  output logic [15:0] scaled
);
  import aicm_pkg::*;

  // ----------------------------------------------------------------
  // Linear map: 4 mA -> start, 20 mA -> end, clamped to 0..65535
  // ----------------------------------------------------------------
  logic signed [18:0] span;
  logic signed [18:0] offs;
  logic signed [37:0] prod;
  logic signed [37:0] res;
  assign span = 19'(signed'({3'b000, scale_end})) - 19'(signed'({3'b000, scale_start}));
  assign offs = 19'(signed'({3'b000, cur_ua})) - 19'(signed'({3'b000, AICM_UA_4MA}));
  assign prod = 38'(offs) * 38'(span);
  assign res = prod / 38'(signed'({22'h0, AICM_UA_SPAN})) + 38'(signed'({22'h0, scale_start}));

  // Registered so the scaled word stays stable between samples
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scaled <= '0;
    end else if (res < 0) begin
      scaled <= '0;
    end else if (res > 38'(signed'({22'h0, AICM_WORD_MAX}))) begin
      scaled <= AICM_WORD_MAX;
    end else begin
      scaled <= res[15:0];
    end
  end
endmodule

/* File: src/aicm_hart_ctl.sv */
// Per-channel HART activation and scan enable resolution
`timescale 1ns/10ps
module aicm_hart_ctl #(
  parameter int NCH = aicm_pkg::AICM_NCH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic indiv_deact_en,
  input wire logic scan_ctl_en,
  input wire logic [NCH-1:0] active_req,
  input wire logic [NCH-1:0] scan_req,
  output logic [NCH-1:0] hart_active,
  output logic [NCH-1:0] hart_scan
);
  import aicm_pkg::*;

  // ----------------------------------------------------------------
  // Resolution: without the unit's permission every channel stays active
  // ----------------------------------------------------------------
  logic [NCH-1:0] act_d;
  logic [NCH-1:0] scan_d;
  assign act_d = indiv_deact_en ? active_req : '1;
  // Scanning defaults on; only active channels are scanned
  assign scan_d = act_d & (scan_ctl_en ? scan_req : '1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hart_active <= '1;
      hart_scan <= '1;
    end else begin
      hart_active <= act_d;
      hart_scan <= scan_d;
    end
  end
endmodule

/* File: verif/aicm_top_sva.sv */
// Concurrent checks on the channel monitor ports
`timescale 1ns/10ps
module aicm_top_chk #(
  parameter int NCH = aicm_pkg::AICM_NCH,
  parameter int FRAME_CYC = aicm_pkg::AICM_FRAME_CYC,
  parameter logic [3:0] SLOT_ID = 4'h0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NCH*aicm_pkg::AICM_WORD_W-1:0] ch_words,
  input wire logic frame_strobe,
  input wire logic [NCH-1:0] hart_active,
  input wire logic [NCH-1:0] hart_scan,
  input wire logic mod_status_en,
  input wire logic hart_indiv_en,
  input wire logic hart_scan_ctl_en,
  input wire logic mod_status_err,
  input wire logic global_status_err,
  input wire logic diag_valid,
  input wire aicm_pkg::aicm_diag_t diag,
  input wire logic diag_ready
);
  import aicm_pkg::*;
  int cnt_q;
  logic seen_q;

  // Cycles since the last frame pulse; the first frame after reset is not timed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= frame_strobe ? 0 : cnt_q + 1;
      seen_q <= seen_q | frame_strobe;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_frame_gap;
    seen_q |-> (frame_strobe ? cnt_q == FRAME_CYC - 1 : cnt_q < FRAME_CYC - 1);
  endproperty
  a_frame_gap: assert property (p_frame_gap)
    else $error("frame period wrong");
  property p_frame_pulse;
    frame_strobe |=> !frame_strobe;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse)
    else $error("frame pulse too long");
  property p_words_hold;
    !frame_strobe |-> $stable(ch_words);
  endproperty
  a_words_hold: assert property (p_words_hold)
    else $error("words changed off frame");
  property p_err_pair;
    mod_status_err == global_status_err;
  endproperty
  a_err_pair: assert property (p_err_pair)
    else $error("module and global error differ");
  property p_err_off;
    !mod_status_en ##1 !mod_status_en |-> !mod_status_err;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("module error while not allowed");
  property p_diag_hold;
    diag_valid && !diag_ready |=> diag_valid && $stable(diag);
  endproperty
  a_diag_hold: assert property (p_diag_hold)
    else $error("report dropped before taken");
  property p_diag_id;
    diag_valid |-> diag.slot == SLOT_ID && !diag.is_output && diag.reason != 2'h0;
  endproperty
  a_diag_id: assert property (p_diag_id)
    else $error("report fields wrong");
  property p_hart_all;
    !hart_indiv_en [*3] |-> &hart_active;
  endproperty
  a_hart_all: assert property (p_hart_all)
    else $error("hart off without permission");
  property p_scan_def;
    (!hart_scan_ctl_en && $stable(hart_active)) [*3] |-> hart_scan == hart_active;
  endproperty
  a_scan_def: assert property (p_scan_def)
    else $error("scan not on by default");
endmodule

bind aicm_top aicm_top_chk #(.NCH(NCH), .FRAME_CYC(FRAME_CYC), .SLOT_ID(SLOT_ID)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .ch_words(ch_words), .frame_strobe(frame_strobe),
  .hart_active(hart_active), .hart_scan(hart_scan), .mod_status_en(mod_status_en),
  .hart_indiv_en(hart_indiv_en), .hart_scan_ctl_en(hart_scan_ctl_en),
  .mod_status_err(mod_status_err), .global_status_err(global_status_err),
  .diag_valid(diag_valid), .diag(diag), .diag_ready(diag_ready)
);

/* File: verif/aicm_unit_model.sv */
// Communication unit model: collects words each frame, takes reports
`timescale 1ns/10ps
module aicm_unit_model #(
  parameter int NCH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NCH*aicm_pkg::AICM_WORD_W-1:0] ch_words,
  input wire logic frame_strobe,
  input wire logic diag_valid,
  input wire aicm_pkg::aicm_diag_t diag,
  input wire logic [3:0] ready_lag,
  output logic diag_ready
);
  import aicm_pkg::*;
  logic [NCH*AICM_WORD_W-1:0] words_q;
  aicm_diag_t got_q;
  int n_diag;
  logic [3:0] wait_q;

  // Ready is held off for ready_lag + 1 cycles to mimic a busy unit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diag_ready <= 1'b0;
      wait_q <= 4'h0;
      n_diag <= 0;
    end else if (diag_valid && diag_ready) begin
      diag_ready <= 1'b0;
      wait_q <= 4'h0;
      got_q <= diag;
      n_diag <= n_diag + 1;
    end else if (diag_valid) begin
      wait_q <= wait_q + 4'h1;
      diag_ready <= (wait_q >= ready_lag);
    end
    if (frame_strobe) begin
      words_q <= ch_words;
    end
  end
endmodule

/* File: verif/aicm_top_bench.sv */
// Self-checking bench for the channel monitor
`timescale 1ns/10ps
module aicm_top_bench;
  import aicm_pkg::*;
  localparam int FC = 20;
  localparam logic [3:0] SLOT = 4'h5; // Arbitrary slot number
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sample_valid = 4'h0;
  logic [11:0] code = 12'h000;
  aicm_ch_cfg_t c = '0;
  logic mod_status_en = 1'b0;
  logic hart_indiv_en = 1'b0;
  logic hart_scan_ctl_en = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [63:0] ch_words;
  logic frame_strobe, diag_valid, diag_ready, mod_status_err, global_status_err;
  logic [3:0] hart_active, hart_scan;
  aicm_diag_t diag;
  int fail_count = 0;
  int check_count = 0;
  int n0;

  aicm_top #(.FRAME_CYC(FC), .SLOT_ID(SLOT)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample_code({4{code}}), .ch_cfg({4{c}}), .mod_status_en(mod_status_en),
    .hart_indiv_en(hart_indiv_en), .hart_scan_ctl_en(hart_scan_ctl_en),
    .ch_words(ch_words), .frame_strobe(frame_strobe), .hart_active(hart_active),
    .hart_scan(hart_scan), .mod_status_err(mod_status_err),
    .global_status_err(global_status_err), .diag_valid(diag_valid), .diag(diag),
    .diag_ready(diag_ready)
  );
  aicm_unit_model u_unit (
    .core_clk(core_clk), .rst_n(rst_n), .ch_words(ch_words), .frame_strobe(frame_strobe),
    .diag_valid(diag_valid), .diag(diag), .ready_lag(lag), .diag_ready(diag_ready)
  );

  // 10 MHz clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // Inputs move 2 ns after the edge so the sampling edge never races them
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic next_frame;
    int k;
    for (k = 0; k < 4 * FC; k++) begin
      cyc(1);
      if (frame_strobe === 1'b1) begin
        break;
      end
    end
    if (k == 4 * FC) begin
      $display("Error frame_strobe expected 1 seen 0");
      fail_count++;
      tally_and_finish;
    end
  endtask
  // Two frames guarantee the sample has passed the pipeline into the unit
  task automatic feed(input logic [11:0] v);
    code = v;
    sample_valid = 4'hf;
    cyc(1);
    sample_valid = 4'h0;
    next_frame;
    next_frame;
    cyc(1);
  endtask

  initial begin
    c.scale_start = AICM_SCALE_START_DEF;
    c.scale_end = AICM_SCALE_END_DEF;
    c.short_ua = AICM_SHORT_DEF_UA;
    c.break_ua = AICM_BREAK_DEF_UA;
    c.subst_value = 16'habcd;
    c.sim_value = 16'h1234;
    c.err_mode = AICM_ERR_SUBST;
    c.hart_scan = 1'b1;
    cyc(12);
    chk("hart_reset", 16'h000f, {12'h0, hart_active});
    rst_n = 1'b1;
    // Full code is 24993 uA: 10000 + 20993 * 40000 / 16000 = 62482, over range
    // Zero code sits 4000 uA under the span start and maps exactly to 0
    // Substitution stays idle while detection is off
    feed(12'hfff);
    chk("word_top", 16'hf412, u_unit.words_q[47:32]);
    feed(12'h000);
    chk("word_bottom", 16'h0000, u_unit.words_q[47:32]);
    c.with_status = 1'b1;
    feed(12'h000);
    chk("word_live_zero", 16'h0001, u_unit.words_q[47:32]);
    c.scale_end = 16'hc351;
    feed(12'hfff);
    // Span 40001 gives 62483; no status nibble with a non-default scale
    chk("word_custom_scale", 16'hf413, u_unit.words_q[47:32]);
    c.scale_end = AICM_SCALE_END_DEF;
    c.with_status = 1'b0;
    c.sim_mode = 1'b1;
    feed(12'h7d0);
    chk("word_sim", 16'h1234, u_unit.words_q[47:32]);
    // Break on all channels while simulating
    c.lfd_en = 1'b1;
    c.err_mode = AICM_ERR_CURRENT;
    mod_status_en = 1'b1;
    n0 = u_unit.n_diag;
    feed(12'h000);
    chk("word_current", 16'h1234, u_unit.words_q[47:32]);
    chk("diag_count", 16'(n0 + 4), 16'(u_unit.n_diag));
    chk("diag_break", {7'h0, SLOT, 2'h3, 1'b0, AICM_REASON_BREAK}, {7'h0, u_unit.got_q});
    chk("mod_err", 16'h0003, {14'h0, mod_status_err, global_status_err});
    feed(12'h7d0);
    c.err_mode = AICM_ERR_LAST;
    feed(12'h000);
    c.sim_value = 16'h5678;
    feed(12'h000);
    chk("word_last", 16'h1234, u_unit.words_q[47:32]);
    feed(12'h7d0);
    chk("word_restored", 16'h5678, u_unit.words_q[47:32]);
    // Short with a slow unit and status bits on
    c.sim_mode = 1'b0;
    c.err_mode = AICM_ERR_SUBST;
    c.with_status = 1'b1;
    lag = 4'h3;
    feed(12'hfff);
    cyc(FC);
    chk("word_subst", 16'habc2, u_unit.words_q[47:32]);
    chk("diag_short", {7'h0, SLOT, 2'h3, 1'b0, AICM_REASON_SHORT}, {7'h0, u_unit.got_q});
    mod_status_en = 1'b0;
    cyc(2);
    chk("mod_err_off", 16'h0000, {14'h0, mod_status_err, global_status_err});
    // HART activation and scan permissions
    c.hart_active = 1'b0;
    cyc(3);
    chk("hart_forced", 16'h00ff, {8'h0, hart_active, hart_scan});
    hart_indiv_en = 1'b1;
    cyc(3);
    chk("hart_off", 16'h0000, {8'h0, hart_active, hart_scan});
    c.hart_active = 1'b1;
    c.hart_scan = 1'b0;
    cyc(3);
    chk("hart_scan_def", 16'h00ff, {8'h0, hart_active, hart_scan});
    hart_scan_ctl_en = 1'b1;
    cyc(3);
    chk("hart_scan_off", 16'h00f0, {8'h0, hart_active, hart_scan});
    tally_and_finish;
  end
endmodule
